// [clk_pd_pkg.sv]
/*
  Constants for the sample-clock divider and power-state control block.
  Assumes a single 250 MHz ref_clk domain; nothing else.
*/
package clk_pd_pkg;
  localparam logic [8:0] SYNC_CTRL_ADDR   = 9'h109;
  localparam int         ADDR_W           = 9;
  localparam int         DATA_W           = 8;
  localparam int         SYNC_EN_BIT      = 0;
  localparam int         SYNC_ONCE_BIT    = 1;
  localparam int         DIV_LSB          = 4;
  localparam int         DIV_W            = 3;
  localparam logic [7:0] SYNC_CTRL_RESET  = 8'h00;
  localparam logic [7:0] PWR_CTRL_ADDR_LO = 8'h08;
  localparam logic [8:0] PWR_CTRL_ADDR    = 9'h008;
  localparam int         PWR_PD_BIT       = 0;
  localparam int         PWR_STBY_BIT     = 1;
  localparam int         DCS_EN_BIT       = 2;
  localparam logic [7:0] PWR_CTRL_RESET   = 8'h04;
  localparam logic [8:0] STATUS_ADDR      = 9'h00a;
  localparam int         MAX_DIV          = 8;
  localparam int         CLK_MHZ          = 250;
  localparam int         DCS_MIN_MHZ      = 20;
  localparam int         RELOCK_NS        = 5000;
  localparam int         RELOCK_CYC       = RELOCK_NS * CLK_MHZ / 1000;
  localparam int         DCS_MAX_DIV      = CLK_MHZ / DCS_MIN_MHZ;
  localparam int         WAKE_SHIFT       = 2;
  localparam int         WAKE_STBY_CYC    = 16;
  typedef enum logic [1:0] {PS_RUN, PS_DOWN, PS_STBY, PS_WAKE} pwr_state_t;
endpackage

// [clk_divider.sv]
/*
  Integer divider producing one-cycle sample enables and, with dcsEn, a 50% phase at even ratios.
  Assumes sync pulses are already edge-detected in the same clock.
*/
`timescale 1ns/1ns
module clk_divider #(
  parameter int MAX_DIV = 8
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] ratioM1,
  input  wire logic       realign,
  input  wire logic       dcsEn,
  output logic            sampleEn,
  output logic            phaseHigh
);
  logic [2:0] cnt_q;
  logic [2:0] half;

  assign half = 3'((4'(ratioM1) + 4'h1) >> 1);

  always_ff @(posedge clk) begin
    if (!rst_n || !run || realign) begin
      cnt_q <= 3'h0;
    end else if (cnt_q >= ratioM1) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  assign sampleEn = run && (cnt_q == 3'h0);

  // without stabilizer the high phase is one input cycle
  assign phaseHigh = run && (dcsEn ? (cnt_q < half) || (ratioM1 == 3'h0)
                                   : (cnt_q == 3'h0));
endmodule

// [wake_timer.sv]
/*
  Measures time spent powered down and times the matching wake-up.
  Assumes downing stays high for the whole time spent powered down.
*/
`timescale 1ns/1ns
module wake_timer #(
  parameter int CNT_W = 20,
  parameter int SHIFT = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic downing,
  input  wire logic waking,
  input  wire logic [CNT_W-1:0] minWake,
  output logic      done
);
  logic [CNT_W-1:0] down_q;
  logic [CNT_W-1:0] wake_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      down_q <= '0;
    end else if (downing) begin
      if (down_q != '1) down_q <= down_q + 1'b1;
    end else if (waking && done) begin
      down_q <= '0;
    end
  end

  // wake length scales with the discharge time, floor at minWake
  always_ff @(posedge clk) begin
    if (!rst_n || !waking) begin
      wake_q <= '0;
    end else if (!done) begin
      wake_q <= wake_q + 1'b1;
    end
  end

  assign done = (wake_q >= (down_q >> SHIFT)) && (wake_q >= minWake);
endmodule

// [adc_clock_pd.sv]
/*
  Sample-clock divider, sync realignment, duty stabilizer status and
  power-state control for a quad pipelined converter.
  Assumes a serial-port decoder delivers single-cycle register writes and
  reads with the printed addresses; all inputs synchronous to ref_clk.
*/
// How it works
// - input clock divided by integer ratio from one to eight.
// - register bits zero and one pick sync every pulse or first-after-write.
// - accepted sync resets divider to its initial state.
// - stabilizer enabled gives internal clock nominal fifty percent duty; divider gives it at even ratios only, ratio one held high.
// - stabilizer marked inoperative below about twenty megahertz clock.
// - after rate change, relock takes up to five microseconds; host waits.
// - power-down entered by serial command or power_down_pin high.
// - output drivers float in power-down.
// - power_down_pin low returns from pin-initiated power-down.
// - reference, buffer, bias and internal clock off in power-down.
// - wake-up time grows with time spent powered down.
// - serial standby keeps reference powered for faster wake-up.
// - samples taken on rising edge of internal sample clock.
`timescale 1ns/1ns
module adc_clock_pd
  import clk_pd_pkg::*;
#(
  parameter int RELOCK_CYCLES = clk_pd_pkg::RELOCK_CYC,
  parameter int WAKE_W        = 20
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         syncIn,
  input  wire logic                         power_down_pin,
  input  wire logic                         regWr,
  input  wire logic                         regRd,
  input  wire logic [clk_pd_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [clk_pd_pkg::DATA_W-1:0] regWdata,
  output logic      [clk_pd_pkg::DATA_W-1:0] regRdata,
  output logic                              sampleClk,
  output logic                              sampleStrobe,
  output logic                              outDriveEn,
  output logic                              refPowerOn,
  output logic                              biasPowerOn,
  output logic                              clockReady,
  output logic                              dcsActive
);
  import clk_pd_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [DATA_W-1:0] syncCtrl_q;
  logic [DATA_W-1:0] pwrCtrl_q;
  logic              armed_q;
  logic              syncPrev_q;
  logic              syncEdge;
  logic              syncAccept;
  logic [DIV_W-1:0]  ratioM1;
  logic              divSample;
  logic              divPhase;
  logic              clockRun;
  logic              wakeDone;
  pwr_state_t        pstate_q;
  logic              pinDown;
  logic              spiDown;
  logic              spiStby;
  logic [15:0]       relock_q;
  logic [DIV_W-1:0]  ratioLast_q;
  logic              dcsLow;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction

  // divider ratio and sync mode share one register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncCtrl_q <= SYNC_CTRL_RESET;
    end else if (regWr && hit(regAddr, SYNC_CTRL_ADDR)) begin
      syncCtrl_q <= regWdata;
    end
  end

  // power-down, standby and stabilizer enable
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwrCtrl_q <= PWR_CTRL_RESET;
    end else if (regWr && hit(regAddr, PWR_CTRL_ADDR)) begin
      pwrCtrl_q <= regWdata;
    end
  end

  // read data holds between reads; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (hit(regAddr, SYNC_CTRL_ADDR)) begin
        regRdata <= syncCtrl_q;
      end else if (hit(regAddr, PWR_CTRL_ADDR)) begin
        regRdata <= pwrCtrl_q;
      end else if (hit(regAddr, STATUS_ADDR)) begin
        regRdata <= {3'h0, armed_q, dcsLow, clockReady, pstate_q};
      end else begin
        regRdata <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // sync detection and realignment
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncPrev_q <= 1'b0;
    end else begin
      syncPrev_q <= syncIn;
    end
  end

  assign syncEdge = syncIn && !syncPrev_q;

  // once-mode: write arms, first edge disarms; the write wins a tie
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (regWr && hit(regAddr, SYNC_CTRL_ADDR)) begin
      armed_q <= 1'b1;
    end else if (syncAccept) begin
      armed_q <= 1'b0;
    end
  end

  assign syncAccept = syncEdge && syncCtrl_q[SYNC_EN_BIT]
                      && (!syncCtrl_q[SYNC_ONCE_BIT] || armed_q);

  assign ratioM1 = syncCtrl_q[DIV_LSB +: DIV_W];

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  assign pinDown = power_down_pin;
  assign spiDown = pwrCtrl_q[PWR_PD_BIT];
  assign spiStby = pwrCtrl_q[PWR_STBY_BIT];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pstate_q <= PS_RUN;
    end else begin
      case (pstate_q)
        PS_RUN: begin
          if (pinDown || spiDown) begin
            pstate_q <= PS_DOWN;
          end else if (spiStby) begin
            pstate_q <= PS_STBY;
          end
        end
        PS_DOWN: begin
          // pin and serial request must both be gone before waking
          if (!pinDown && !spiDown) begin
            pstate_q <= PS_WAKE;
          end
        end
        PS_STBY: begin
          if (pinDown || spiDown) begin
            pstate_q <= PS_DOWN;
          end else if (!spiStby) begin
            pstate_q <= PS_WAKE;
          end
        end
        PS_WAKE: begin
          if (pinDown || spiDown) begin
            pstate_q <= PS_DOWN;
          end else if (wakeDone) begin
            pstate_q <= PS_RUN;
          end
        end
        default: begin
          pstate_q <= PS_RUN;
        end
      endcase
    end
  end

  assign clockRun = (pstate_q == PS_RUN);

  wake_timer #(
    .CNT_W (WAKE_W),
    .SHIFT (WAKE_SHIFT)
  ) u_wake (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .downing (pstate_q == PS_DOWN),
    .waking  (pstate_q == PS_WAKE),
    .minWake (WAKE_W'(WAKE_STBY_CYC)),
    .done    (wakeDone)
  );

  // ------------------------------------------------------------
  // divider and stabilizer
  // ------------------------------------------------------------
  clk_divider #(
    .MAX_DIV (MAX_DIV)
  ) u_div (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .run       (clockRun),
    .ratioM1   (ratioM1),
    .realign   (syncAccept),
    .dcsEn     (pwrCtrl_q[DCS_EN_BIT]),
    .sampleEn  (divSample),
    .phaseHigh (divPhase)
  );

  // divided rate below the loop's floor: loop reported inoperative
  assign dcsLow = (int'(ratioM1) + 1) > DCS_MAX_DIV;

  // relock window restarts on a ratio change or on leaving run
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ratioLast_q <= 3'h0;
    end else begin
      ratioLast_q <= ratioM1;
    end
  end

  // ready drops one cycle after the window opens and rises one cycle after it closes,
  // so it still reads high for the first two cycles at a new ratio
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      relock_q <= 16'(RELOCK_CYCLES);
    end else if (ratioM1 != ratioLast_q || !clockRun) begin
      relock_q <= 16'(RELOCK_CYCLES);
    end else if (relock_q != 16'h0) begin
      relock_q <= relock_q - 16'h1;
    end
  end

  // ------------------------------------------------------------
  // outputs, all registered
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sampleClk <= 1'b0;
    end else begin
      sampleClk <= divPhase;
    end
  end

  // one pulse per divided period marks the sampling instant
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sampleStrobe <= 1'b0;
    end else begin
      sampleStrobe <= divSample;
    end
  end

  // low floats every output driver; only the run state drives
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      outDriveEn <= 1'b0;
    end else begin
      outDriveEn <= clockRun;
    end
  end

  // only full power-down drops the reference; standby keeps it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      refPowerOn <= 1'b0;
    end else begin
      refPowerOn <= (pstate_q != PS_DOWN);
    end
  end

  // bias returns during wake so discharged nodes recharge first
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      biasPowerOn <= 1'b0;
    end else begin
      biasPowerOn <= clockRun || (pstate_q == PS_WAKE);
    end
  end

  // ready only in run with the relock window fully spent
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      clockReady <= 1'b0;
    end else begin
      clockReady <= clockRun && (relock_q == 16'h0);
    end
  end

  // reported on only when enabled, running and fast enough
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dcsActive <= 1'b0;
    end else begin
      dcsActive <= pwrCtrl_q[DCS_EN_BIT] && !dcsLow && clockRun;
    end
  end
endmodule

// [adc_clock_pd_props.sv]
/* Port checker for adc_clock_pd.
   Assumes one ref_clk domain; bound to every adc_clock_pd instance. */
`timescale 1ns/1ns
module adc_clock_pd_props
  import clk_pd_pkg::*;
(
  input wire logic                          ref_clk,
  input wire logic                          rst_n,
  input wire logic                          power_down_pin,
  input wire logic                          regWr,
  input wire logic                          regRd,
  input wire logic [clk_pd_pkg::ADDR_W-1:0] regAddr,
  input wire logic [clk_pd_pkg::DATA_W-1:0] regWdata,
  input wire logic [clk_pd_pkg::DATA_W-1:0] regRdata,
  input wire logic                          sampleStrobe,
  input wire logic                          outDriveEn,
  input wire logic                          refPowerOn,
  input wire logic                          biasPowerOn,
  input wire logic                          clockReady,
  input wire logic                          dcsActive
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // named steps
  // ------------------------------------------------------------
  // four samples: one to enter down, one for outputs to drop, margin
  sequence pinHeld;
    power_down_pin [*4];
  endsequence
  sequence syncWrRd;
    regWr && regAddr == SYNC_CTRL_ADDR ##2 regRd && regAddr == SYNC_CTRL_ADDR;
  endsequence
  pd_pin_off_a: assert property (
    pinHeld |-> !outDriveEn && !refPowerOn && !biasPowerOn) else $error("powered in pd");
  pd_clk_stop_a: assert property (
    pinHeld |-> !sampleStrobe) else $error("strobe in pd");
  ref_before_drive_a: assert property (
    !refPowerOn |-> !outDriveEn) else $error("drive without ref");
  ready_in_run_a: assert property (
    clockReady |-> outDriveEn && biasPowerOn) else $error("ready outside run");
  sync_readback_a: assert property (
    syncWrRd |=> (regRdata & 8'h73) == ($past(regWdata, 3) & 8'h73))
    else $error("sync ctrl readback");
  dcs_off_a: assert property (
    regWr && regAddr == PWR_CTRL_ADDR && !regWdata[DCS_EN_BIT] |=> ##[0:2] !dcsActive)
    else $error("stabilizer stays on");
  rate_flag_a: assert property (
    regRd && regAddr == STATUS_ADDR |=> !regRdata[3]) else $error("rate flag set");
  serial_pd_a: assert property (
    regWr && regAddr == PWR_CTRL_ADDR && regWdata[PWR_PD_BIT] |=> ##[1:3] !outDriveEn)
    else $error("serial pd ignored");
endmodule

bind adc_clock_pd adc_clock_pd_props i_props (
  .ref_clk        (ref_clk),
  .rst_n          (rst_n),
  .power_down_pin (power_down_pin),
  .regWr          (regWr),
  .regRd          (regRd),
  .regAddr        (regAddr),
  .regWdata       (regWdata),
  .regRdata       (regRdata),
  .sampleStrobe   (sampleStrobe),
  .outDriveEn     (outDriveEn),
  .refPowerOn     (refPowerOn),
  .biasPowerOn    (biasPowerOn),
  .clockReady     (clockReady),
  .dcsActive      (dcsActive)
);

// [host_model.sv]
/* Host model: serial register access, sync input and power-down pin.
   Assumes ref_clk from the bench; changes its outputs at falling edges. */
`timescale 1ns/1ns
module host_model
  import clk_pd_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          clockReady,
  input  wire logic [clk_pd_pkg::DATA_W-1:0] regRdata,
  output logic                               syncIn,
  output logic                               power_down_pin,
  output logic                               regWr,
  output logic                               regRd,
  output logic      [clk_pd_pkg::ADDR_W-1:0] regAddr,
  output logic      [clk_pd_pkg::DATA_W-1:0] regWdata
);
  initial begin
    syncIn = 1'b0;
    power_down_pin = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
  end
  // released lines show the inverse, never a convenient held value
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regWr = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge ref_clk);
    regWr = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    regRd = 1'b1;
    regAddr = a;
    @(negedge ref_clk);
    regRd = 1'b0;
    regAddr = ~a;
    d = regRdata;
  endtask
  task automatic setSync(input logic v);
    @(negedge ref_clk);
    syncIn = v;
  endtask
  task automatic setPin(input logic v);
    @(negedge ref_clk);
    power_down_pin = v;
  endtask
  // clock not relied on until relocked; lead-in lets a restart show
  task automatic waitReady(output int n);
    n = 3;
    repeat (3) @(negedge ref_clk);
    while (clockReady !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
endmodule

// [testbench.sv]
/* Self-checking bench for adc_clock_pd.
   Assumes host_model drives every input except clock and reset. */
`timescale 1ns/1ns
module testbench;
  import clk_pd_pkg::*;
  logic              ref_clk;
  logic              rst_n;
  logic              syncIn, power_down_pin, regWr, regRd;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata;
  logic              sampleClk, sampleStrobe, outDriveEn, refPowerOn;
  logic              biasPowerOn, clockReady, dcsActive;
  int                err_count = 0;
  int                checked = 0;
  int                cyc = 0;
  int                a, b, a0, b0, n, w1, w2;
  logic              prev;

  adc_clock_pd #(
    .RELOCK_CYCLES (8)
  ) i_adc_clock_pd (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .syncIn         (syncIn),
    .power_down_pin (power_down_pin),
    .regWr          (regWr),
    .regRd          (regRd),
    .regAddr        (regAddr),
    .regWdata       (regWdata),
    .regRdata       (regRdata),
    .sampleClk      (sampleClk),
    .sampleStrobe   (sampleStrobe),
    .outDriveEn     (outDriveEn),
    .refPowerOn     (refPowerOn),
    .biasPowerOn    (biasPowerOn),
    .clockReady     (clockReady),
    .dcsActive      (dcsActive)
  );
  host_model i_host (
    .ref_clk        (ref_clk),
    .clockReady     (clockReady),
    .regRdata       (regRdata),
    .syncIn         (syncIn),
    .power_down_pin (power_down_pin),
    .regWr          (regWr),
    .regRd          (regRd),
    .regAddr        (regAddr),
    .regWdata       (regWdata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input string s, input int lo, input int hi, input logic [7:0] g);
    checked++;
    if (^g === 1'bx || g < lo || g > hi) begin
      err_count++;
      $display("mismatch %s exp %0d..%0d got %0d", s, lo, hi, g);
    end
  endtask
  task automatic rdChk(input string s, input logic [8:0] ad, input logic [7:0] m,
                       input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(ad, d);
    chk(s, e, e, d & m);
  endtask
  // cycles from now up to the next strobe
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
    end while (sampleStrobe !== 1'b1 && c < 64);
  endtask
  task automatic syncDly(input int k, output int d);
    gap(d);
    repeat (k) @(negedge ref_clk);
    i_host.setSync(1'b1);
    gap(d);
    i_host.setSync(1'b0);
  endtask
  task automatic conclude();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    i_host.waitReady(n);
    rdChk("pwr reset", PWR_CTRL_ADDR, 8'hff, PWR_CTRL_RESET);
    rdChk("sync reset", SYNC_CTRL_ADDR, 8'hff, SYNC_CTRL_RESET);
    rdChk("unmapped", 9'h0aa, 8'hff, 8'h00);
    rdChk("status", STATUS_ADDR, 8'h0b, 8'h00);
    i_host.wr(SYNC_CTRL_ADDR, 8'h03);
    rdChk("sync rw", SYNC_CTRL_ADDR, 8'h73, 8'h03);
    $display("test registers done");
    for (int r = 1; r <= MAX_DIV; r++) begin
      i_host.wr(SYNC_CTRL_ADDR, 8'((r - 1) << DIV_LSB));
      i_host.waitReady(n);
      if (r > 1) chk("relock", 7, 12, 8'(n));
      gap(n);
      gap(n);
      chk("period", r, r, 8'(n));
    end
    $display("test divider done");
    i_host.wr(SYNC_CTRL_ADDR, 8'h30);
    i_host.waitReady(n);
    a = 0;
    b = 0;
    n = 0;
    prev = sampleClk;
    repeat (32) begin
      @(negedge ref_clk);
      a += int'(sampleClk);
      b += int'(sampleClk && !prev);
      n += int'(sampleStrobe);
      prev = sampleClk;
    end
    chk("high count", 16, 16, 8'(a));
    chk("rises", 8, 8, 8'(b));
    chk("strobes", 8, 8, 8'(n));
    chk("dcs on", 1, 1, {7'h0, dcsActive});
    i_host.wr(PWR_CTRL_ADDR, 8'h00);
    repeat (3) @(negedge ref_clk);
    chk("dcs off", 0, 0, {7'h0, dcsActive});
    i_host.wr(PWR_CTRL_ADDR, PWR_CTRL_RESET);
    $display("test stabilizer done");
    i_host.wr(SYNC_CTRL_ADDR, 8'h70);
    i_host.waitReady(n);
    syncDly(1, a0);
    syncDly(3, b0);
    chk("no realign", 2, 2, 8'(a0 - b0));
    i_host.wr(SYNC_CTRL_ADDR, 8'h71);
    syncDly(1, a);
    syncDly(3, b);
    chk("first sync", 2, 2, 8'(a));
    chk("every sync", 2, 2, 8'(b));
    i_host.wr(SYNC_CTRL_ADDR, 8'h73);
    rdChk("armed", STATUS_ADDR, 8'h10, 8'h10);
    syncDly(1, n);
    chk("once first", a, a, 8'(n));
    rdChk("disarmed", STATUS_ADDR, 8'h10, 8'h00);
    syncDly(3, n);
    chk("once second", b0, b0, 8'(n));
    i_host.wr(SYNC_CTRL_ADDR, 8'h71);
    i_host.setSync(1'b1);
    gap(n);
    gap(n);
    gap(n);
    chk("long sync", 8, 8, 8'(n));
    i_host.setSync(1'b0);
    $display("test sync done");
    i_host.setPin(1'b1);
    repeat (8) @(negedge ref_clk);
    n = 0;
    repeat (32) begin
      @(negedge ref_clk);
      n += int'(sampleStrobe);
    end
    chk("pd strobes", 0, 0, 8'(n));
    chk("pd outputs", 0, 0, {5'h0, outDriveEn, refPowerOn, biasPowerOn});
    rdChk("pd state", STATUS_ADDR, 8'h03, 8'h01);
    i_host.setPin(1'b0);
    i_host.waitReady(w1);
    chk("short wake", 22, 30, 8'(w1));
    i_host.setPin(1'b1);
    repeat (400) @(negedge ref_clk);
    i_host.setPin(1'b0);
    i_host.waitReady(w2);
    chk("wake growth", w1 + 82, w1 + 86, 8'(w2));
    i_host.wr(PWR_CTRL_ADDR, 8'h05);
    repeat (4) @(negedge ref_clk);
    chk("serial pd", 0, 0, {7'h0, outDriveEn});
    i_host.wr(PWR_CTRL_ADDR, PWR_CTRL_RESET);
    i_host.waitReady(n);
    i_host.wr(PWR_CTRL_ADDR, 8'h06);
    repeat (400) @(negedge ref_clk);
    chk("stby power", 2, 2, {6'h0, refPowerOn, biasPowerOn});
    rdChk("stby state", STATUS_ADDR, 8'h03, 8'h02);
    i_host.wr(PWR_CTRL_ADDR, PWR_CTRL_RESET);
    i_host.waitReady(n);
    chk("stby wake", 0, w2 - 1, 8'(n));
    $display("test power done");
    conclude();
  end
endmodule
